/* File: src/pxrb_pkg.sv */
// constants, masks and types for the extended management register bank
package pxrb_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [5:0] PXRB_IDX_STATUS = 6'h10;
  localparam logic [5:0] PXRB_IDX_FCC = 6'h14;
  localparam logic [5:0] PXRB_IDX_REC = 6'h15;
  localparam logic [5:0] PXRB_IDX_PCS = 6'h16;
  localparam logic [5:0] PXRB_IDX_RBR = 6'h17;
  localparam logic [5:0] PXRB_IDX_LED = 6'h18;
  localparam logic [5:0] PXRB_IDX_TRANSCEIVER_CONTROL = 6'h19;
  localparam logic [5:0] PXRB_IDX_TBT = 6'h1a;
  localparam logic [5:0] PXRB_IDX_CDC = 6'h1b;
  localparam logic [5:0] PXRB_IDX_ENERGY_DETECT_CTRL = 6'h1d;
  localparam logic [5:0] PXRB_IDX_IRQ_ST = 6'h20;
  localparam logic [5:0] PXRB_IDX_IRQ_MASK = 6'h21;

  // live status layout: implemented bits, latched-high bits, latched-low bits
  localparam logic [15:0] PXRB_STS_USED = 16'h7f7f;
  localparam logic [15:0] PXRB_STS_LH = 16'h2960;
  localparam logic [15:0] PXRB_STS_LL = 16'h0001;

  // software-writable bits of each control register
  localparam logic [15:0] PXRB_PCS_WMASK = 16'h0fa7;
  localparam logic [15:0] PXRB_RBR_WMASK = 16'hbff3;
  localparam logic [15:0] PXRB_LED_WMASK = 16'h0012;
  localparam logic [15:0] PXRB_TRANSCEIVER_CONTROL_WMASK = 16'hfdbf;
  localparam logic [15:0] PXRB_TBT_WMASK = 16'h0fc3;
  localparam logic [15:0] PXRB_CDC_WMASK = 16'h0037;
  localparam logic [15:0] PXRB_ENERGY_DETECT_CTRL_WMASK = 16'hf800;

  // values after reset
  localparam logic [15:0] PXRB_PCS_RST = 16'h0000;
  localparam logic [15:0] PXRB_RBR_RST = 16'h0000;
  localparam logic [15:0] PXRB_LED_RST = 16'h0000;
  localparam logic [15:0] PXRB_TRANSCEIVER_CONTROL_RST = 16'h0000;
  localparam logic [15:0] PXRB_TBT_RST = 16'h0000;
  localparam logic [15:0] PXRB_CDC_RST = 16'h0000;
  localparam logic [15:0] PXRB_ENERGY_DETECT_CTRL_RST = 16'h0000;
  localparam logic [7:0] PXRB_CNT_RST = 8'h00;
  localparam logic [7:0] PXRB_CNT_MAX = 8'hff;

  // field positions
  localparam int PXRB_BIT_LINK = 0;
  localparam int PXRB_BIT_BIST_START = 8;
  localparam int PXRB_BIT_BIST_STATUS = 9;
  localparam int PXRB_BIT_RBR_OVF = 3;
  localparam int PXRB_BIT_RBR_UNF = 2;
  localparam int PXRB_BIT_POLARITY = 4;
  localparam int PXRB_BIT_ED_PWR = 10;

  // interrupt status / mask layout
  localparam int PXRB_IRQ_W = 4;
  localparam int PXRB_IRQ_FC = 0;
  localparam int PXRB_IRQ_RXE = 1;
  localparam int PXRB_IRQ_LINK_LOST = 2;
  localparam int PXRB_IRQ_BIST_DONE = 3;
  localparam logic [PXRB_IRQ_W-1:0] PXRB_IRQ_RST = 4'h0;

  // bus answer phase
  typedef enum logic {PXRB_IDLE, PXRB_ANSWER} pxrb_phase_t;

endpackage

/* File: src/pxrb_bank.sv */
// extended management register bank with avalon-mm slave and interrupt
module pxrb_bank
  import pxrb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] status_live_i,
  input wire logic false_carrier_evt_i,
  input wire logic rx_error_evt_i,
  input wire logic [1:0] elast_flags_i,
  input wire logic bist_done_i,
  input wire logic bist_status_i,
  input wire logic polarity_i,
  input wire logic [7:0] bist_err_count_i,
  input wire logic ed_pwr_state_i,
  input wire logic [1:0] ed_met_i,
  input wire logic [3:0] ed_err_count_i,
  input wire logic [3:0] ed_data_count_i,
  output logic [15:0] pcs_cfg_o,
  output logic [15:0] rbr_ctrl_o,
  output logic [15:0] led_ctrl_o,
  output logic [15:0] phy_ctrl_o,
  output logic [15:0] tbt_ctrl_o,
  output logic [15:0] cdc_ctrl_o,
  output logic [15:0] energy_detect_ctrl_ctrl_o,
  output logic irq_o
);

  typedef struct packed {
    pxrb_phase_t phase;
    logic [15:0] rdata;
    logic [15:0] lat_hi;
    logic [15:0] lat_lo;
    logic [7:0] fc_cnt;
    logic [7:0] rxe_cnt;
    logic [1:0] elast_lat;
    logic [15:0] pcs;
    logic [15:0] reduced_mii_bypass_ctrl;
    logic [15:0] led;
    logic [15:0] transceiver_control;
    logic [15:0] tbt;
    logic [15:0] cdc;
    logic [15:0] energy_detect_ctrl;
    logic [PXRB_IRQ_W-1:0] irq_st;
    logic [PXRB_IRQ_W-1:0] irq_mask;
  } pxrb_state_t;

  pxrb_state_t st_r;
  pxrb_state_t st_nxt;

  logic [5:0] idx;
  logic req;
  logic accept;
  logic rd_acc;
  logic wr_acc;
  logic [15:0] rd_val;
  logic [15:0] sts_view;

  // merge writable bits of a write, honouring the two low byte lanes
  function automatic logic [15:0] wr_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [15:0] wmask);
    logic [15:0] m;
    m = wmask & {{8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (wd[15:0] & m);
  endfunction

  // saturating event counter; a read clears it but an event in that cycle still counts
  function automatic logic [7:0] cnt_step(input logic [7:0] c, input logic evt,
                                          input logic clr);
    logic [7:0] base;
    base = clr ? PXRB_CNT_RST : c;
    if (evt && base != PXRB_CNT_MAX) begin
      return base + 8'h01;
    end
    return base;
  endfunction

  // bus request decode; a request is taken in the idle phase, answered one cycle later
  assign idx = avs_address_i[7:2];
  assign req = avs_read_i | avs_write_i;
  assign accept = req && (st_r.phase == PXRB_IDLE);
  assign rd_acc = accept && avs_read_i;
  assign wr_acc = accept && avs_write_i;
  assign avs_waitrequest_o = req && (st_r.phase != PXRB_ANSWER);

  // status view: live bits overlaid with the latched ones
  always_comb begin
    sts_view = status_live_i & ~PXRB_STS_LH & ~PXRB_STS_LL;
    sts_view = sts_view | ((status_live_i | st_r.lat_hi) & PXRB_STS_LH);
    sts_view = sts_view | (status_live_i & ~st_r.lat_lo & PXRB_STS_LL);
    sts_view = sts_view & PXRB_STS_USED;
  end

  // read multiplexer over registers and live inputs
  always_comb begin
    rd_val = 16'h0000;
    case (idx)
      PXRB_IDX_STATUS: rd_val = sts_view;
      PXRB_IDX_FCC: rd_val = {8'h00, st_r.fc_cnt};
      PXRB_IDX_REC: rd_val = {8'h00, st_r.rxe_cnt};
      PXRB_IDX_PCS: rd_val = st_r.pcs;
      PXRB_IDX_RBR: rd_val = st_r.reduced_mii_bypass_ctrl | {12'h000, st_r.elast_lat, 2'h0};
      PXRB_IDX_LED: rd_val = st_r.led;
      PXRB_IDX_TRANSCEIVER_CONTROL: begin
        rd_val = st_r.transceiver_control;
        rd_val[PXRB_BIT_BIST_STATUS] = bist_status_i;
      end
      PXRB_IDX_TBT: begin
        rd_val = st_r.tbt;
        rd_val[PXRB_BIT_POLARITY] = polarity_i;
      end
      PXRB_IDX_CDC: rd_val = st_r.cdc | {bist_err_count_i, 8'h00};
      PXRB_IDX_ENERGY_DETECT_CTRL: rd_val = st_r.energy_detect_ctrl | {5'h00, ed_pwr_state_i, ed_met_i,
                                           ed_err_count_i, ed_data_count_i};
      PXRB_IDX_IRQ_ST: rd_val = {12'h000, st_r.irq_st};
      PXRB_IDX_IRQ_MASK: rd_val = {12'h000, st_r.irq_mask};
      default: rd_val = 16'h0000;
    endcase
  end

  // next state of the whole bank
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = accept ? PXRB_ANSWER : PXRB_IDLE;
    if (rd_acc) begin
      st_nxt.rdata = rd_val;
    end

    // latch high and latch low, both re-armed by a status read
    if (rd_acc && idx == PXRB_IDX_STATUS) begin
      st_nxt.lat_hi = status_live_i & PXRB_STS_LH;
      st_nxt.lat_lo = ~status_live_i & PXRB_STS_LL;
    end else begin
      st_nxt.lat_hi = st_r.lat_hi | (status_live_i & PXRB_STS_LH);
      st_nxt.lat_lo = st_r.lat_lo | (~status_live_i & PXRB_STS_LL);
    end

    st_nxt.fc_cnt = cnt_step(st_r.fc_cnt, false_carrier_evt_i,
                             rd_acc && idx == PXRB_IDX_FCC);
    st_nxt.rxe_cnt = cnt_step(st_r.rxe_cnt, rx_error_evt_i,
                              rd_acc && idx == PXRB_IDX_REC);

    // elastic buffer flags held until the register is read
    if (rd_acc && idx == PXRB_IDX_RBR) begin
      st_nxt.elast_lat = elast_flags_i;
    end else begin
      st_nxt.elast_lat = st_r.elast_lat | elast_flags_i;
    end

    // bist start drops once the run is done
    if (bist_done_i) begin
      st_nxt.transceiver_control[PXRB_BIT_BIST_START] = 1'b0;
    end

    // register writes; masks keep read-only and reserved bits untouched
    if (wr_acc) begin
      case (idx)
        PXRB_IDX_PCS: st_nxt.pcs = wr_merge(st_r.pcs, avs_writedata_i, avs_byteenable_i,
                                            PXRB_PCS_WMASK);
        PXRB_IDX_RBR: st_nxt.reduced_mii_bypass_ctrl = wr_merge(st_r.reduced_mii_bypass_ctrl, avs_writedata_i, avs_byteenable_i,
                                            PXRB_RBR_WMASK);
        PXRB_IDX_LED: st_nxt.led = wr_merge(st_r.led, avs_writedata_i, avs_byteenable_i,
                                            PXRB_LED_WMASK);
        // a new start write wins over a done in the same cycle
        PXRB_IDX_TRANSCEIVER_CONTROL: st_nxt.transceiver_control = wr_merge(st_nxt.transceiver_control, avs_writedata_i,
                                                avs_byteenable_i, PXRB_TRANSCEIVER_CONTROL_WMASK);
        PXRB_IDX_TBT: st_nxt.tbt = wr_merge(st_r.tbt, avs_writedata_i, avs_byteenable_i,
                                            PXRB_TBT_WMASK);
        PXRB_IDX_CDC: st_nxt.cdc = wr_merge(st_r.cdc, avs_writedata_i, avs_byteenable_i,
                                            PXRB_CDC_WMASK);
        PXRB_IDX_ENERGY_DETECT_CTRL: st_nxt.energy_detect_ctrl = wr_merge(st_r.energy_detect_ctrl, avs_writedata_i, avs_byteenable_i,
                                              PXRB_ENERGY_DETECT_CTRL_WMASK);
        PXRB_IDX_IRQ_ST: begin
          if (avs_byteenable_i[0]) begin
            st_nxt.irq_st = st_r.irq_st & ~avs_writedata_i[PXRB_IRQ_W-1:0];
          end
        end
        PXRB_IDX_IRQ_MASK: begin
          if (avs_byteenable_i[0]) begin
            st_nxt.irq_mask = avs_writedata_i[PXRB_IRQ_W-1:0];
          end
        end
        default: st_nxt.irq_mask = st_r.irq_mask;
      endcase
    end

    // sticky events set after the clear so a same-cycle event is never lost
    if (false_carrier_evt_i) begin
      st_nxt.irq_st[PXRB_IRQ_FC] = 1'b1;
    end
    if (rx_error_evt_i) begin
      st_nxt.irq_st[PXRB_IRQ_RXE] = 1'b1;
    end
    if (!status_live_i[PXRB_BIT_LINK] && !st_r.lat_lo[PXRB_BIT_LINK]) begin
      st_nxt.irq_st[PXRB_IRQ_LINK_LOST] = 1'b1;
    end
    if (bist_done_i) begin
      st_nxt.irq_st[PXRB_IRQ_BIST_DONE] = 1'b1;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_r <= '{phase: PXRB_IDLE, rdata: 16'h0000, lat_hi: 16'h0000, lat_lo: 16'h0000,
                fc_cnt: PXRB_CNT_RST, rxe_cnt: PXRB_CNT_RST, elast_lat: 2'h0,
                pcs: PXRB_PCS_RST, reduced_mii_bypass_ctrl: PXRB_RBR_RST, led: PXRB_LED_RST,
                transceiver_control: PXRB_TRANSCEIVER_CONTROL_RST, tbt: PXRB_TBT_RST, cdc: PXRB_CDC_RST,
                energy_detect_ctrl: PXRB_ENERGY_DETECT_CTRL_RST, irq_st: PXRB_IRQ_RST, irq_mask: PXRB_IRQ_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign avs_readdata_o = {16'h0000, st_r.rdata};
  assign pcs_cfg_o = st_r.pcs;
  assign rbr_ctrl_o = st_r.reduced_mii_bypass_ctrl;
  assign led_ctrl_o = st_r.led;
  assign phy_ctrl_o = st_r.transceiver_control;
  assign tbt_ctrl_o = st_r.tbt;
  assign cdc_ctrl_o = st_r.cdc;
  assign energy_detect_ctrl_ctrl_o = st_r.energy_detect_ctrl;
  assign irq_o = |(st_r.irq_st & st_r.irq_mask);

  // request taken, then answered with waitrequest low
  sequence seq_taken;
    req && st_r.phase == PXRB_IDLE;
  endsequence

  sequence seq_answered;
    st_r.phase == PXRB_ANSWER && !avs_waitrequest_o;
  endsequence

  property p_answer;
    @(posedge ref_clk_i) disable iff (rst_i)
      seq_taken |=> seq_answered;
  endproperty

  chk_bus_answer: assert property (p_answer)
    else $error("request not answered in the next cycle");

  chk_ed_follow: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      rd_acc && idx == PXRB_IDX_ENERGY_DETECT_CTRL |=> st_r.rdata[9:8] == $past(ed_met_i))
    else $error("energy met flags do not follow their events");

  chk_bist_selfclr: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      bist_done_i && !(wr_acc && idx == PXRB_IDX_TRANSCEIVER_CONTROL)
      |=> !st_r.transceiver_control[PXRB_BIT_BIST_START]
      ##1 (!st_r.transceiver_control[PXRB_BIT_BIST_START] || $past(wr_acc)))
    else $error("bist start did not clear after done");

  chk_cor_clear: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      rd_acc && idx == PXRB_IDX_FCC && !false_carrier_evt_i
      |=> st_r.fc_cnt == 8'h00 && st_r.rdata[7:0] == $past(st_r.fc_cnt))
    else $error("false carrier count not returned and cleared by read");

  chk_ll_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      st_r.lat_lo[PXRB_BIT_LINK] && rd_acc && idx == PXRB_IDX_STATUS
      |=> st_r.rdata[PXRB_BIT_LINK] == 1'b0)
    else $error("latched low link bit not reported");

  chk_lh_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      status_live_i[13] && !(rd_acc && idx == PXRB_IDX_STATUS)
      |=> st_r.lat_hi[13] ##1 (st_r.lat_hi[13] || $past(rd_acc)))
    else $error("latched high receive error not held");

  chk_fixed_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      rd_acc && idx == PXRB_IDX_STATUS |=> (st_r.rdata & ~PXRB_STS_USED) == 16'h0000)
    else $error("fixed status bits not zero");

  chk_unmapped_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      rd_acc && (idx == 6'h11 || idx == 6'h1c || idx == 6'h1e) |=> st_r.rdata == 16'h0000)
    else $error("reserved address read not zero");

  chk_irq_level: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      false_carrier_evt_i && st_r.irq_mask[PXRB_IRQ_FC]
      ##1 st_r.irq_mask[PXRB_IRQ_FC] |-> irq_o)
    else $error("unmasked event did not raise interrupt");

  // a clear in the same cycle must never hide a new event
  chk_irq_set_wins: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      false_carrier_evt_i |=> st_r.irq_st[PXRB_IRQ_FC])
    else $error("false carrier event lost its sticky bit");

  // waitrequest stays high while a request waits in the idle phase
  chk_bus_wait: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      req && st_r.phase == PXRB_IDLE |-> avs_waitrequest_o)
    else $error("waitrequest low before the request was taken");

  // a full counter holds its top value rather than wrapping to zero
  chk_cnt_saturate: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      st_r.fc_cnt == PXRB_CNT_MAX && false_carrier_evt_i && !(rd_acc && idx == PXRB_IDX_FCC)
      |=> st_r.fc_cnt == PXRB_CNT_MAX)
    else $error("false carrier count wrapped past its top");

  chk_cor_nowrite: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      wr_acc && idx == PXRB_IDX_REC && !rx_error_evt_i
      |=> st_r.rxe_cnt == $past(st_r.rxe_cnt))
    else $error("receive error count changed by a write");

  chk_elast_hold: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
      elast_flags_i[1] && !(rd_acc && idx == PXRB_IDX_RBR) |=> st_r.elast_lat[1])
    else $error("elastic overflow flag not held");

endmodule

/* File: tb/pxrb_mgmt_master.sv */
// management-side avalon-mm master model for the register bank
module pxrb_mgmt_master (
  input wire logic ref_clk_i,
  output logic [7:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle with no request at time zero
  initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0000_0000;
    avs_byteenable_o = 4'h0;
  end

  // waitrequest sampled at each rising edge; only the bench watchdog ends a wait
  task automatic await();
    do begin
      @(posedge ref_clk_i);
    end while (avs_waitrequest_i !== 1'b0);
  endtask

  // request held until the edge where waitrequest is seen low
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] be);
    @(posedge ref_clk_i);
    avs_address_o <= {idx, 2'b00};
    avs_writedata_o <= {16'h0000, d};
    avs_byteenable_o <= be;
    avs_write_o <= 1'b1;
    await();
    avs_write_o <= 1'b0;
  endtask

  // read data taken at the answer edge, then the request drops
  task automatic rd(input logic [5:0] idx, output logic [15:0] d);
    @(posedge ref_clk_i);
    avs_address_o <= {idx, 2'b00};
    avs_read_o <= 1'b1;
    await();
    d = avs_readdata_i[15:0];
    avs_read_o <= 1'b0;
  endtask
endmodule

/* File: tb/phy_extended_register_bank_test.sv */
// self-checking bench for the extended management register bank
module phy_extended_register_bank_test import pxrb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [5:0] idx; logic [15:0] exp;} pxrb_row_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr;
  logic rd, wr, wreq, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [15:0] live = 16'h0000;
  logic [2:0] evt = 3'h0; // false carrier, rx error, bist done
  logic [1:0] elast = 2'h0;
  logic [1:0] ed_met = 2'h0;
  logic bst = 1'b0, pol = 1'b0, edp = 1'b0;
  logic [7:0] berr = 8'h00;
  logic [3:0] ede = 4'h0, edd = 4'h0;
  logic [15:0] o_pcs, o_rbr, o_led, o_phy, o_tbt, o_cdc, o_ed;
  int err_total = 0;
  int tests_run = 0;
  // writable registers give their mask back; reserved places stay zero
  pxrb_row_t rows [11] = '{'{PXRB_IDX_PCS, PXRB_PCS_WMASK}, '{PXRB_IDX_RBR, PXRB_RBR_WMASK},
    '{PXRB_IDX_LED, PXRB_LED_WMASK}, '{PXRB_IDX_TRANSCEIVER_CONTROL, PXRB_TRANSCEIVER_CONTROL_WMASK},
    '{PXRB_IDX_TBT, PXRB_TBT_WMASK}, '{PXRB_IDX_CDC, PXRB_CDC_WMASK},
    '{PXRB_IDX_ENERGY_DETECT_CTRL, PXRB_ENERGY_DETECT_CTRL_WMASK}, '{6'h11, 16'h0000}, '{6'h1c, 16'h0000},
    '{6'h1e, 16'h0000}, '{PXRB_IDX_FCC, 16'h0000}};

  // 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  pxrb_bank dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .status_live_i(live),
    .false_carrier_evt_i(evt[0]), .rx_error_evt_i(evt[1]), .elast_flags_i(elast),
    .bist_done_i(evt[2]), .bist_status_i(bst), .polarity_i(pol), .bist_err_count_i(berr),
    .ed_pwr_state_i(edp), .ed_met_i(ed_met), .ed_err_count_i(ede), .ed_data_count_i(edd),
    .pcs_cfg_o(o_pcs), .rbr_ctrl_o(o_rbr), .led_ctrl_o(o_led), .phy_ctrl_o(o_phy),
    .tbt_ctrl_o(o_tbt), .cdc_ctrl_o(o_cdc), .energy_detect_ctrl_ctrl_o(o_ed), .irq_o(irq));

  pxrb_mgmt_master mst (.ref_clk_i(ref_clk_i), .avs_address_o(addr), .avs_read_o(rd),
    .avs_write_o(wr), .avs_writedata_o(wdata), .avs_byteenable_o(be),
    .avs_readdata_i(rdata), .avs_waitrequest_i(wreq));

  // compare helpers, one per result width
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic rc(input logic [5:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    mst.rd(idx, d);
    chk16($sformatf("register %h", idx), exp, d);
  endtask
  // one-cycle event pulses with a gap, so each counts once
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      evt <= m;
      @(posedge ref_clk_i);
      evt <= 3'h0;
    end
  endtask
  function automatic logic [15:0] outv(input logic [5:0] idx);
    case (idx)
      PXRB_IDX_PCS: return o_pcs;
      PXRB_IDX_RBR: return o_rbr;
      PXRB_IDX_LED: return o_led;
      PXRB_IDX_TRANSCEIVER_CONTROL: return o_phy;
      PXRB_IDX_TBT: return o_tbt;
      PXRB_IDX_CDC: return o_cdc;
      PXRB_IDX_ENERGY_DETECT_CTRL: return o_ed;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic fin(input string name);
    $display("test %s done", name);
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    results();
  end

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      rc(rows[i].idx, 16'h0000);
      mst.wr(rows[i].idx, 16'hffff, 4'h3);
      rc(rows[i].idx, rows[i].exp);
      chk16("output copy", rows[i].exp, outv(rows[i].idx));
      mst.wr(rows[i].idx, 16'h0000, 4'h3);
    end
    mst.wr(PXRB_IDX_PCS, 16'hffff, 4'h1);
    rc(PXRB_IDX_PCS, PXRB_PCS_WMASK & 16'h00ff);
    mst.wr(PXRB_IDX_PCS, 16'h0000, 4'h3);
    fin("register rows");
    // counters ignore writes, read back their count and are zeroed by it
    for (int k = 0; k < 2; k++) begin
      pulse(3'(1 << k), 3);
      mst.wr(PXRB_IDX_FCC + 6'(k), 16'h0000, 4'h3);
      rc(PXRB_IDX_FCC + 6'(k), 16'h0003);
      rc(PXRB_IDX_FCC + 6'(k), 16'h0000);
    end
    pulse(3'h1, 260);
    rc(PXRB_IDX_FCC, 16'h00ff);
    fin("counters");
    @(posedge ref_clk_i);
    live <= 16'h0001;
    rc(PXRB_IDX_STATUS, 16'h0000);
    rc(PXRB_IDX_STATUS, 16'h0001);
    @(posedge ref_clk_i);
    live <= 16'h0000;
    @(posedge ref_clk_i);
    live <= 16'h0001;
    rc(PXRB_IDX_STATUS, 16'h0000);
    rc(PXRB_IDX_STATUS, 16'h0001);
    @(posedge ref_clk_i);
    live <= 16'hffff;
    rc(PXRB_IDX_STATUS, PXRB_STS_USED);
    @(posedge ref_clk_i);
    live <= 16'h0001;
    rc(PXRB_IDX_STATUS, PXRB_STS_LH | 16'h0001);
    rc(PXRB_IDX_STATUS, 16'h0001);
    @(posedge ref_clk_i);
    elast <= 2'b11;
    @(posedge ref_clk_i);
    elast <= 2'b00;
    rc(PXRB_IDX_RBR, 16'h000c);
    rc(PXRB_IDX_RBR, 16'h0000);
    fin("latches");
    mst.wr(PXRB_IDX_TRANSCEIVER_CONTROL, 16'h0100, 4'h3);
    rc(PXRB_IDX_TRANSCEIVER_CONTROL, 16'h0100);
    chk16("phy control out", 16'h0100, o_phy);
    pulse(3'h4, 1);
    rc(PXRB_IDX_TRANSCEIVER_CONTROL, 16'h0000);
    @(posedge ref_clk_i);
    {bst, pol, berr, edp, ed_met, ede, edd} <= {2'b11, 8'ha5, 3'b111, 4'h6, 4'h9};
    rc(PXRB_IDX_TRANSCEIVER_CONTROL, 16'h0200);
    rc(PXRB_IDX_TBT, 16'h0010);
    rc(PXRB_IDX_CDC, 16'ha500);
    rc(PXRB_IDX_ENERGY_DETECT_CTRL, 16'h0769);
    @(posedge ref_clk_i);
    ed_met <= 2'b00;
    rc(PXRB_IDX_ENERGY_DETECT_CTRL, 16'h0469);
    fin("self clearing");
    // every event kind has left its sticky bit; mask gates the line
    rc(PXRB_IDX_IRQ_ST, 16'h000f);
    mst.wr(PXRB_IDX_IRQ_ST, 16'h000f, 4'h3);
    rc(PXRB_IDX_IRQ_ST, 16'h0000);
    pulse(3'h1, 1);
    @(negedge ref_clk_i);
    chk1("irq masked", 1'b0, irq);
    mst.wr(PXRB_IDX_IRQ_MASK, 16'h0001, 4'h3);
    @(negedge ref_clk_i);
    chk1("irq unmasked", 1'b1, irq);
    mst.wr(PXRB_IDX_IRQ_ST, 16'h0001, 4'h3);
    @(negedge ref_clk_i);
    chk1("irq cleared", 1'b0, irq);
    // a fresh event with the mask already open raises the line at once
    pulse(3'h1, 1);
    @(negedge ref_clk_i);
    chk1("irq on event", 1'b1, irq);
    fin("interrupt");
    // reset in mid-run returns configuration to its reset value
    mst.wr(PXRB_IDX_PCS, 16'hffff, 4'h3);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rc(PXRB_IDX_PCS, PXRB_PCS_RST);
    chk16("pcs out", PXRB_PCS_RST, o_pcs);
    // the pending interrupt left before reset must be gone
    chk1("irq after reset", 1'b0, irq);
    fin("second reset");
    results();
  end
endmodule
